// file: testbench/tb_vitc_user_bit_gpo_decoder.sv
// Self-checking bench for the timecode user-bit output decoder.
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_vitc_user_bit_gpo_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import vgpo_pkg::*;
  logic mclk, rst_n, ce, lnk_clk, lnk_dat, lnk_en, lnk_fld;
  logic video_ok, cpu_ok, psu_fault, frame_jmp;
  logic led_fault, led_video, led_data, frame_fault, std_625;
  vgpo_sw_t sw;
  wire [5:0] outs;
  logic [89:0] flip;
  int err_total, checks, cyc;
  vgpo_embedder emb (.flip(flip), .lnk_clk(lnk_clk), .lnk_dat(lnk_dat), .lnk_en(lnk_en),
    .lnk_fld(lnk_fld));
  // Hold-off counts are shortened; the long one outlasts one whole data field.
  vgpo_decoder #(.HOLD_SHORT_CYC(200), .HOLD_LONG_CYC(3000), .BLINK_CYC(16)) dut (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .lnk_clk(lnk_clk), .lnk_dat(lnk_dat),
    .lnk_en(lnk_en), .lnk_fld(lnk_fld), .video_ok(video_ok), .cpu_ok(cpu_ok),
    .psu_fault(psu_fault), .frame_jmp(frame_jmp), .sw(sw),
    .output_line_one(outs[0]), .output_line_two(outs[1]), .output_line_three(outs[2]),
    .output_line_four(outs[3]), .output_line_five(outs[4]), .output_line_six(outs[5]),
    .led_fault(led_fault), .led_video(led_video), .led_data(led_data),
    .frame_fault(frame_fault), .std_625(std_625));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] ub_of(input logic [5:0] st);
    return {2'b10, st[5:4], st[3:0], 24'h080839};
  endfunction
  task automatic finish_test();
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 95000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic set(input vgpo_sw_t v);
    @(posedge mclk) sw <= v;
    wt(6);
  endtask
  task automatic good(input int ln, input logic [5:0] st);
    emb.fld();
    emb.lines(ln + 1, ln, ub_of(st));
    wt(10);
  endtask
  task automatic lossy();
    emb.fld();
    emb.fld();
    wt(6);
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_fixed();
    set(8'h8A);
    good(10, 6'h25);
    `CHK(outs, 6'h25)
    `CHK(led_data, 1'b1)
    `CHK(led_fault, 1'b0)
    @(posedge mclk) ce <= 1'b0;
    set(8'h0A);
    `CHK(outs, 6'h25)
    @(posedge mclk) ce <= 1'b1;
    wt(6);
    `CHK(outs, 6'h1A)
    set(8'h8A);
  endtask
  task automatic t_refuse();
    logic [31:0] u;
    for (int i = 0; i < 10; i++) begin
      u = ub_of(6'h12);
      if (i < 6) u[4*i] = ~u[4*i];
      if (i == 6) u[31] = 1'b0;
      flip[85] = (i == 8);
      flip[1] = (i == 9);
      emb.fld();
      emb.lines(12, (i == 7) ? 11 : 10, u);
      flip = '0;
      lossy();
      `CHK(led_data, 1'b0)
      `CHK(outs, 6'h25)
      good(10, 6'h25);
    end
  endtask
  task automatic t_drop();
    set(8'h4A);
    good(10, 6'h3F);
    `CHK(outs, 6'h00)
    lossy();
    `CHK(outs, 6'h3F)
    `CHK(led_fault, 1'b1)
  endtask
  task automatic t_range();
    for (int ln = 6; ln < 10; ln += 3) begin
      set(8'h80 | 8'(ln));
      emb.fld();
      emb.lines(ln + 1, ln, ub_of(6'h01));
      lossy();
      `CHK(led_data, 1'b0)
    end
    set(8'h9F);
    good(31, 6'h01);
    `CHK(outs, 6'h01)
  endtask
  task automatic t_auto();
    set(8'hA0);
    good(12, 6'h02);
    `CHK(outs, 6'h02)
    good(14, 6'h03);
    `CHK(outs, 6'h02)
    good(14, 6'h03);
    `CHK(outs, 6'h02)
    wt(3000);
    good(14, 6'h03);
    `CHK(outs, 6'h03)
    set(8'h80);
    lossy();
    emb.lines(13, 12, ub_of(6'h04));
    wt(10);
    `CHK(outs, 6'h04)
    set(8'hA0);
    lossy();
    emb.lines(13, 12, ub_of(6'h08));
    wt(3000);
    good(14, 6'h10);
    `CHK(outs, 6'h08)
  endtask
  task automatic t_status();
    int tg;
    logic prev;
    `CHK(led_video, 1'b1)
    @(posedge mclk) cpu_ok <= 1'b0;
    wt(6);
    tg = 0;
    prev = led_fault;
    repeat (64) begin
      @(posedge mclk);
      if (led_fault !== prev) tg++;
      prev = led_fault;
    end
    `CHK(tg > 1, 1'b1)
    `CHK(frame_fault, 1'b1)
    @(posedge mclk) cpu_ok <= 1'b1;
    psu_fault <= 1'b1;
    frame_jmp <= 1'b0;
    wt(6);
    `CHK(led_fault, 1'b1)
    `CHK(frame_fault, 1'b0)
    @(posedge mclk) psu_fault <= 1'b0;
    video_ok <= 1'b0;
    frame_jmp <= 1'b1;
    wt(6);
    `CHK(led_video, 1'b0)
    `CHK(frame_fault, 1'b1)
    @(posedge mclk) video_ok <= 1'b1;
    wt(6);
  endtask
  task automatic t_std();
    emb.fld();
    emb.lines(300, 0, '0);
    set(8'h86);
    emb.fld();
    emb.lines(300, 6, ub_of(6'h05));
    wt(10);
    `CHK(std_625, 1'b1)
    `CHK(outs, 6'h05)
    lossy();
    `CHK(std_625, 1'b0)
  endtask
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    video_ok = 1'b1;
    cpu_ok = 1'b1;
    psu_fault = 1'b0;
    frame_jmp = 1'b1;
    sw = 8'h8A;
    flip = '0;
    repeat (3) @(posedge mclk);
    `CHK(outs, 6'h3F)
    rst_n <= 1'b1;
    wt(4);
    t_fixed();
    t_refuse();
    t_drop();
    t_range();
    t_auto();
    t_status();
    t_std();
    finish_test();
  end
endmodule // tb_vitc_user_bit_gpo_decoder
`default_nettype wire

// file: testbench/vgpo_embedder.sv
// Behavioural remote embedder that drives timecode frames onto the link pins.
`default_nettype none
module vgpo_embedder (
  input wire logic [89:0] flip,
  output logic lnk_clk,
  output logic lnk_dat,
  output logic lnk_en,
  output logic lnk_fld
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    lnk_clk = 1'b0;
    lnk_dat = 1'b1;
    lnk_en = 1'b0;
    lnk_fld = 1'b0;
  end
  // user nibbles, sync bits and a check byte that clears the remainder.
  function automatic logic [89:0] word(input logic [31:0] ub);
    logic [89:0] w;
    logic [7:0] c;
    w = '0;
    for (int k = 0; k < 9; k++) begin
      w[10*k] = 1'b1;
      if (k < 8) w[10*k+6 +: 4] = ub[4*k +: 4];
    end
    // Bits set in flip go out inverted; low bits before the check byte is formed,
    // so a sync error can be sent with a clean check byte.
    w[81:0] = w[81:0] ^ flip[81:0];
    c = 8'h00;
    for (int i = 0; i < 82; i++) c = {c[6:0], c[7] ^ w[i]};
    for (int i = 82; i < 90; i++) begin
      w[i] = c[7] ^ flip[i];
      c = {c[6:0], 1'b0};
    end
    return w;
  endfunction
  // Pins move 2 ns after the calling edge and every step lasts whole clock periods,
  // so no pin changes on a sampling edge of the decoder.
  task automatic fld();
    #2 lnk_fld = 1'b1;
    #60;
    lnk_fld = 1'b0;
    #58;
  endtask
  // Lines other than tgt carry an empty frame; the clock stands still outside frames.
  task automatic lines(input int n, input int tgt, input logic [31:0] ub);
    logic [89:0] w;
    w = word(ub);
    for (int ln = 1; ln <= n; ln++) begin
      #2 lnk_en = 1'b1;
      if (ln == tgt) begin
        for (int i = 0; i < 90; i++) begin
          lnk_dat = w[i];
          #80 lnk_clk = 1'b1;
          #80 lnk_clk = 1'b0;
        end
        lnk_dat = ~w[89];
      end
      #60 lnk_en = 1'b0;
      #58;
    end
  endtask
endmodule // vgpo_embedder
`default_nettype wire

// file: verilog/vgpo_decoder.sv
// Top of the decoder: line selection, hunt and lock, outputs and indicators.
`default_nettype none
`include "vgpo_map.svh"
// How it works
// R1: Groups one to six must match pattern.
// R2: Group seven drives outputs one to four.
// R3: Group eight gives outputs five, six; MSB set.
// R4: Only valid timecode on selected line decoded.
// R5: Five switches form binary line number.
// R6: Line range 10-31 or 6-31 by standard.
// R7: All line switches off means automatic hunt.
// R8: Hunt stops and locks on good line.
// R9: Resume hunt only after hold-off expires.
// R10: Switch six picks one or five seconds.
// R11: Switch seven: hold or drop outputs on loss.
// R12: Switch eight sets output polarity.
// R13: Fault lit on video, data or supply loss.
// R14: Fault flashes while processor not running.
// R15: Video indicator follows input video presence.
// R16: Data indicator lit while good data arrives.
// R17: Fault forwarded to chassis only with jumper on.
// R18: Detect 525 or 625 line video itself.
// R19: Outputs follow the remote embedder inputs.
// R20: Invalid line setting means data missing.
// R21: Hold-off starts at first bad field, cancels.
module vgpo_decoder #(
  parameter int HOLD_SHORT_CYC = `VGPO_HOLD_SHORT_S * `VGPO_MCLK_HZ,
  parameter int HOLD_LONG_CYC = `VGPO_HOLD_LONG_S * `VGPO_MCLK_HZ,
  parameter int BLINK_CYC = `VGPO_BLINK_MS * `VGPO_CYC_PER_MS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic lnk_clk,
  input wire logic lnk_dat,
  input wire logic lnk_en,
  input wire logic lnk_fld,
  input wire logic video_ok,
  input wire logic cpu_ok,
  input wire logic psu_fault,
  input wire logic frame_jmp,
  input wire vgpo_pkg::vgpo_sw_t sw,
  output logic output_line_one,
  output logic output_line_two,
  output logic output_line_three,
  output logic output_line_four,
  output logic output_line_five,
  output logic output_line_six,
  output logic led_fault,
  output logic led_video,
  output logic led_data,
  output logic frame_fault,
  output logic std_625
);
  import vgpo_pkg::*;

  function automatic logic line_ok(input vgpo_line_t ln, input logic is_625);
    line_ok = (ln >= (is_625 ? `VGPO_LINE_MIN_625 : `VGPO_LINE_MIN_525)) &&
              (ln <= `VGPO_LINE_MAX);
  endfunction

  function automatic logic drive_lvl(input logic active, input logic pol_high);
    drive_lvl = pol_high ? active : !active;
  endfunction

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  logic [15:0] meta_r;
  logic [15:0] sync_r;
  logic lnk_clk_s, lnk_dat_s, lnk_en_s, lnk_fld_s;
  logic video_s, cpu_ok_s, psu_fault_s, frame_jmp_s;
  vgpo_sw_t sw_s;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 16'h0000;
      sync_r <= 16'h0000;
    end else if (ce) begin
      meta_r <= {frame_jmp, psu_fault, cpu_ok, video_ok, lnk_fld, lnk_en, lnk_dat, lnk_clk, sw};
      sync_r <= meta_r;
    end
  end

  assign {frame_jmp_s, psu_fault_s, cpu_ok_s, video_s, lnk_fld_s, lnk_en_s, lnk_dat_s,
          lnk_clk_s, sw_s} = sync_r;

  // --------------------------------------------------------------------------
  // Link edges
  // --------------------------------------------------------------------------
  logic clk_d_r, en_d_r, fld_d_r;
  logic bit_stb, frame_start, frame_end, field_start;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clk_d_r <= 1'b0;
      en_d_r <= 1'b0;
      fld_d_r <= 1'b0;
    end else if (ce) begin
      clk_d_r <= lnk_clk_s;
      en_d_r <= lnk_en_s;
      fld_d_r <= lnk_fld_s;
    end
  end

  assign bit_stb = lnk_clk_s && !clk_d_r;
  assign frame_start = lnk_en_s && !en_d_r;
  assign frame_end = !lnk_en_s && en_d_r;
  assign field_start = lnk_fld_s && !fld_d_r;

  logic word_done, word_ok;
  vgpo_ub_t ub;

  vgpo_vitc_rx u_rx (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .frame(lnk_en_s),
    .frame_end(frame_end),
    .bit_stb(bit_stb),
    .bit_val(lnk_dat_s),
    .word_done(word_done),
    .word_ok(word_ok),
    .user_bits(ub)
  );

  // --------------------------------------------------------------------------
  // Line count and standard detection
  // --------------------------------------------------------------------------
  logic [8:0] line_cnt_r;
  // R18: lines per field
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      line_cnt_r <= 9'h000;
      std_625 <= 1'b0;
    end else if (ce) begin
      if (field_start) begin
        line_cnt_r <= 9'h000;
        std_625 <= line_cnt_r >= `VGPO_LINES_625_MIN;
      end else if (frame_start && line_cnt_r != 9'h1FF) begin
        line_cnt_r <= line_cnt_r + 9'h001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Word acceptance
  // --------------------------------------------------------------------------
  vgpo_mode_t mode_r;
  vgpo_line_t lock_line_r;
  vgpo_line_t sel, cur_line;
  logic auto_mode, sel_valid, small_line, pattern_ok, line_match, take_word;

  // R5: binary line number
  assign sel = sw_s[4:0];
  // R7: all off is automatic
  assign auto_mode = (sel == `VGPO_LINE_AUTO);
  // R6: legal line range
  assign sel_valid = line_ok(sel, std_625);
  assign small_line = (line_cnt_r[8:5] == 4'h0);
  assign cur_line = line_cnt_r[4:0];
  // R1: fixed group pattern
  assign pattern_ok = (ub[`VGPO_FIXED_MSB:0] == `VGPO_FIXED_PATTERN) && ub[`VGPO_BG8_MARK];

  always_comb begin
    line_match = 1'b0;
    if (small_line && !auto_mode) begin
      line_match = sel_valid && (cur_line == sel);
    end else if (small_line && mode_r == VGPO_HUNT) begin
      line_match = line_ok(cur_line, std_625);
    end else if (small_line) begin
      line_match = (cur_line == lock_line_r);
    end
  end

  // R4: valid word on selected line
  assign take_word = ce && word_done && word_ok && pattern_ok && video_s && line_match;

  // --------------------------------------------------------------------------
  // Data presence
  // --------------------------------------------------------------------------
  logic data_seen_r, data_ok_r, loss;
  // R16: per-field data presence
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      data_seen_r <= 1'b0;
      data_ok_r <= 1'b0;
    end else if (ce) begin
      if (take_word) begin
        data_seen_r <= 1'b1;
      end else if (field_start) begin
        data_seen_r <= 1'b0;
      end
      // R20: invalid line means missing
      if (!video_s || (!auto_mode && !sel_valid)) begin
        data_ok_r <= 1'b0;
      end else if (take_word) begin
        data_ok_r <= 1'b1;
      end else if (field_start && !data_seen_r) begin
        data_ok_r <= 1'b0;
      end
    end
  end

  assign loss = (field_start && !data_seen_r && !take_word) || !video_s;

  // --------------------------------------------------------------------------
  // Hunt, lock and hold-off
  // --------------------------------------------------------------------------
  logic [31:0] hold_cnt_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= VGPO_HUNT;
      lock_line_r <= `VGPO_LINE_AUTO;
      hold_cnt_r <= 32'h0000_0000;
    end else if (ce) begin
      if (!auto_mode) begin
        mode_r <= VGPO_HUNT;
      end else begin
        case (mode_r)
          VGPO_HUNT: begin
            // R8: lock on first good line
            if (take_word) begin
              mode_r <= VGPO_LOCK;
              lock_line_r <= cur_line;
            end
          end
          VGPO_LOCK: begin
            // R21: start at first bad field
            if (loss) begin
              mode_r <= VGPO_HOLDOFF;
              // R10: switch six picks delay
              hold_cnt_r <= sw_s[`VGPO_SW_HOLD] ? 32'(HOLD_LONG_CYC - 1) :
                                                  32'(HOLD_SHORT_CYC - 1);
            end
          end
          VGPO_HOLDOFF: begin
            // R9: wait before hunting again
            if (take_word) begin
              mode_r <= VGPO_LOCK;
            end else if (hold_cnt_r == 32'h0000_0000) begin
              mode_r <= VGPO_HUNT;
            end else begin
              hold_cnt_r <= hold_cnt_r - 32'h0000_0001;
            end
          end
          default: begin
            mode_r <= VGPO_HUNT;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Output states and pins
  // --------------------------------------------------------------------------
  logic [5:0] gpo_state_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gpo_state_r <= 6'h00;
    end else if (ce) begin
      if (take_word) begin
        // R2: group seven bit order
        // R3: group eight low bits
        gpo_state_r <= {ub[`VGPO_BG8_O6], ub[`VGPO_BG8_O5], ub[`VGPO_BG7_MSB:`VGPO_BG7_LSB]};
      end else if (!data_ok_r && sw_s[`VGPO_SW_DROP]) begin
        // R11: drop on loss
        gpo_state_r <= 6'h00;
      end
    end
  end

  // R12: polarity from switch eight
  // R19: pins follow remote inputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      output_line_one <= 1'b1;
      output_line_two <= 1'b1;
      output_line_three <= 1'b1;
      output_line_four <= 1'b1;
      output_line_five <= 1'b1;
      output_line_six <= 1'b1;
    end else if (ce) begin
      output_line_one <= drive_lvl(gpo_state_r[0], sw_s[`VGPO_SW_POL]);
      output_line_two <= drive_lvl(gpo_state_r[1], sw_s[`VGPO_SW_POL]);
      output_line_three <= drive_lvl(gpo_state_r[2], sw_s[`VGPO_SW_POL]);
      output_line_four <= drive_lvl(gpo_state_r[3], sw_s[`VGPO_SW_POL]);
      output_line_five <= drive_lvl(gpo_state_r[4], sw_s[`VGPO_SW_POL]);
      output_line_six <= drive_lvl(gpo_state_r[5], sw_s[`VGPO_SW_POL]);
    end
  end

  // --------------------------------------------------------------------------
  // Indicators
  // --------------------------------------------------------------------------
  logic [31:0] blink_cnt_r;
  logic blink_r, fault_cond;
  assign fault_cond = !video_s || !data_ok_r || psu_fault_s;

  // The blink runs free so the flash rate is steady whatever else happens.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt_r <= 32'h0000_0000;
      blink_r <= 1'b0;
    end else if (ce) begin
      if (blink_cnt_r >= 32'(BLINK_CYC - 1)) begin
        blink_cnt_r <= 32'h0000_0000;
        blink_r <= !blink_r;
      end else begin
        blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      led_fault <= 1'b1;
      led_video <= 1'b0;
      led_data <= 1'b0;
      frame_fault <= 1'b0;
    end else if (ce) begin
      // R14: flash without processor
      // R13: steady fault otherwise
      led_fault <= !cpu_ok_s ? blink_r : fault_cond;
      // R15: video indicator
      led_video <= video_s;
      led_data <= data_ok_r;
      // R17: chassis report by jumper
      frame_fault <= frame_jmp_s && (fault_cond || !cpu_ok_s);
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_pattern_gate: assert property (ce && word_done && !pattern_ok |=> !$rose(data_seen_r)) // R1
    else $error("bad group pattern accepted");
  a_low_bit_map: assert property (take_word |=> gpo_state_r[3:0] == $past(ub[27:24])) // R2
    else $error("group seven mapping wrong");
  a_high_bit_map: assert property (take_word |=> gpo_state_r[5:4] == $past(ub[29:28])) // R3
    else $error("group eight mapping wrong");
  a_crc_gate: assert property (ce && word_done && !word_ok |=> !$rose(data_seen_r)) // R4
    else $error("invalid word accepted");
  a_line_range: assert property (ce && !auto_mode && !sel_valid |-> !take_word ##1 !data_ok_r) // R6
    else $error("invalid line decoded");
  a_hunt_lock: assert property (ce && auto_mode && mode_r == VGPO_HUNT && take_word
    |=> mode_r == VGPO_LOCK && lock_line_r == $past(cur_line)) // R8
    else $error("hunt did not lock");
  a_holdoff_wait: assert property (ce && auto_mode && mode_r == VGPO_HOLDOFF &&
    hold_cnt_r != 32'h0 |=> mode_r != VGPO_HUNT) // R9
    else $error("hunt resumed early");
  a_drop_outputs: assert property (ce && !take_word && !data_ok_r && sw_s[`VGPO_SW_DROP]
    |=> gpo_state_r == 6'h00) // R11
    else $error("outputs not dropped");
  a_pin_polarity: assert property (ce ##1 ce |-> output_line_one ==
    ($past(sw_s[`VGPO_SW_POL]) ? $past(gpo_state_r[0]) : !$past(gpo_state_r[0]))) // R12
    else $error("output polarity wrong");
  a_frame_gate: assert property (ce && !frame_jmp_s |=> !frame_fault) // R17
    else $error("fault forwarded without jumper");

  c_lock: cover property (mode_r == VGPO_HUNT ##1 mode_r == VGPO_LOCK);
  c_rehunt: cover property (mode_r == VGPO_HOLDOFF ##1 mode_r == VGPO_HUNT);
  c_std_625: cover property ($rose(std_625));
  c_data_up: cover property ($rose(led_data));
endmodule // vgpo_decoder
`default_nettype wire

// file: verilog/vgpo_map.svh
// Named constants for the timecode user-bit output decoder.
`ifndef VGPO_MAP_SVH
`define VGPO_MAP_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define VGPO_MCLK_HZ 100000000
`define VGPO_CYC_PER_MS (`VGPO_MCLK_HZ / 1000)
`define VGPO_HOLD_SHORT_S 1
`define VGPO_HOLD_LONG_S 5
`define VGPO_BLINK_MS 250

// ----------------------------------------------------------------------------
// Timecode word layout
// ----------------------------------------------------------------------------
`define VGPO_WORD_BITS 7'h5A
`define VGPO_GRP_LAST 4'h9
`define VGPO_UB_OFF 4'h6
`define VGPO_UB_GROUPS 4'h8
`define VGPO_SYNC_HI_OFF 4'h0
`define VGPO_SYNC_LO_OFF 4'h1

// ----------------------------------------------------------------------------
// User bit groups
// ----------------------------------------------------------------------------
`define VGPO_FIXED_MSB 23
`define VGPO_FIXED_PATTERN 24'h080839
`define VGPO_BG7_MSB 27
`define VGPO_BG7_LSB 24
`define VGPO_BG8_O6 29
`define VGPO_BG8_O5 28
`define VGPO_BG8_MARK 31

// ----------------------------------------------------------------------------
// Lines, standards and switch positions
// ----------------------------------------------------------------------------
`define VGPO_LINE_MIN_525 5'h0A
`define VGPO_LINE_MIN_625 5'h06
`define VGPO_LINE_MAX 5'h1F
`define VGPO_LINE_AUTO 5'h00
`define VGPO_LINES_625_MIN 9'h120
`define VGPO_SW_HOLD 5
`define VGPO_SW_DROP 6
`define VGPO_SW_POL 7

`endif

// file: verilog/vgpo_pkg.sv
// Types shared by the timecode user-bit output decoder.
`default_nettype none
package vgpo_pkg;
  typedef enum logic [1:0] {VGPO_HUNT, VGPO_LOCK, VGPO_HOLDOFF} vgpo_mode_t;
  typedef logic [7:0] vgpo_sw_t;
  typedef logic [4:0] vgpo_line_t;
  typedef logic [31:0] vgpo_ub_t;
endpackage
`default_nettype wire

// file: verilog/vgpo_vitc_rx.sv
// Serial timecode word receiver: sync bit, length and CRC checks, user bits.
`default_nettype none
`include "vgpo_map.svh"
module vgpo_vitc_rx (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic frame,
  input wire logic frame_end,
  input wire logic bit_stb,
  input wire logic bit_val,
  output logic word_done,
  output logic word_ok,
  output var vgpo_pkg::vgpo_ub_t user_bits
);
  import vgpo_pkg::*;

  logic [6:0] bit_cnt_r;
  logic [3:0] off_r;
  logic [3:0] grp_r;
  logic [7:0] crc_r;
  logic sync_err_r;
  logic [3:0] nib_off;

  assign nib_off = off_r - `VGPO_UB_OFF;

  // --------------------------------------------------------------------------
  // Bit position and checks
  // --------------------------------------------------------------------------
  // R4: sync and crc
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_r <= 7'h00;
      off_r <= 4'h0;
      grp_r <= 4'h0;
      crc_r <= 8'h00;
      sync_err_r <= 1'b0;
    end else if (ce) begin
      if (!frame) begin
        bit_cnt_r <= 7'h00;
        off_r <= 4'h0;
        grp_r <= 4'h0;
        crc_r <= 8'h00;
        sync_err_r <= 1'b0;
      end else if (bit_stb) begin
        // Saturating keeps an overlong word from wrapping back to a legal length.
        if (bit_cnt_r != 7'h7F) begin
          bit_cnt_r <= bit_cnt_r + 7'h01;
        end
        crc_r <= {crc_r[6:0], crc_r[7] ^ bit_val};
        if ((off_r == `VGPO_SYNC_HI_OFF && !bit_val) ||
            (off_r == `VGPO_SYNC_LO_OFF && bit_val)) begin
          sync_err_r <= 1'b1;
        end
        if (off_r == `VGPO_GRP_LAST) begin
          off_r <= 4'h0;
          grp_r <= grp_r + 4'h1;
        end else begin
          off_r <= off_r + 4'h1;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // User bit capture
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      user_bits <= 32'h0000_0000;
    end else if (ce && frame && bit_stb && grp_r < `VGPO_UB_GROUPS &&
                 off_r >= `VGPO_UB_OFF) begin
      user_bits[{grp_r[2:0], nib_off[1:0]}] <= bit_val;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      word_done <= 1'b0;
      word_ok <= 1'b0;
    end else if (ce) begin
      word_done <= frame_end;
      if (frame_end) begin
        word_ok <= (bit_cnt_r == `VGPO_WORD_BITS) && !sync_err_r && (crc_r == 8'h00);
      end
    end
  end
endmodule // vgpo_vitc_rx
`default_nettype wire
